// ---- src/modbus_char_defines.svh ----
`ifndef MODBUS_CHAR_DEFINES_SVH
`define MODBUS_CHAR_DEFINES_SVH
`define CLK_HZ 25000000
`define RATE_4800 4800
`define RATE_9600 9600
`define RATE_19200 19200
`define DIV_4800 (`CLK_HZ / `RATE_4800)
`define DIV_9600 (`CLK_HZ / `RATE_9600)
`define DIV_19200 (`CLK_HZ / `RATE_19200)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_TXDATA 12'h008
`define REG_RXDATA 12'h00C
`define REG_IRQ_STAT 12'h010
`define REG_IRQ_MASK 12'h014
`define CTRL_RATE_LSB 0
`define CTRL_FMT_LSB 4
`define CTRL_PROTO_BIT 8
`define CTRL_ADDR_LSB 16
`define CTRL_RESET 32'h0001_0161
`define IRQ_TX_DONE 0
`define IRQ_RX_DONE 1
`define IRQ_FRAME_ERR 2
`define IRQ_PARITY_ERR 3
`define IRQ_HEX_ERR 4
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'h0_FE
`endif

// ---- src/modbus_char_pkg.sv ----
package modbus_char_pkg;
   typedef enum logic [3:0] {
      LN_IDLE = 4'b0001,
      LN_BITS = 4'b0010,
      LN_STOP = 4'b0100,
      LN_GAP = 4'b1000
   } line_e;
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD = 2'b10
   } parity_e;
endpackage

// ---- src/modbus_serial_char_codec.sv ----
`timescale 1ns/1ps
`include "modbus_char_defines.svh"
// Notes on behaviour
// - Rate code 0/1/2 selects 4800, 9600 or 19200 bit/s.
// - Formats 0-2: ASCII, 7 data bits, N2 / E1 / O1.
// - Formats 3-5: ASCII, 8 data bits, N2 / E1 / O1.
// - Formats 6-8: RTU, 8 data bits, N2 / E1 / O1.
// - ASCII sends each byte as two characters, high nibble first.
// - Nibbles 0-9 map to codes 30h-39h and back.
// - Nibbles 10-15 map to codes 41h-46h and back.
// - RTU sends each byte as one raw 8-bit value.
// - Seven-bit formats use a ten-bit character.
// - Eight-bit formats use an eleven-bit character.
// - Station addresses run 1 to 254 only.
module modbus_serial_char_codec (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_rx,
   output logic line_tx,
   output logic line_tx_oe,
   output logic irq
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [4:0] ist;
      logic [4:0] imask;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic tx_busy;
      logic [7:0] tx_byte;
      logic tx_second;
      modbus_char_pkg::line_e tst;
      logic [15:0] tcnt;
      logic [3:0] tbit;
      logic [10:0] tsh;
      logic tx;
      logic txoe;
      modbus_char_pkg::line_e rst_;
      logic [15:0] rcnt;
      logic [3:0] rbit;
      logic [10:0] rsh;
      logic rx_half;
      logic [3:0] rx_hi;
      logic [7:0] rx_byte;
      logic rx_full;
   } state_s;

   state_s q, d;

   function automatic logic [7:0] nib_to_char(input logic [3:0] n);
      nib_to_char = (n < 4'h0_A) ? 8'h30 + {4'h0, n} :
                    8'h37 + {4'h0, n};
   endfunction

   function automatic logic [4:0] char_to_nib(input logic [7:0] c);
      // Bit 4 flags a character outside 0-9, A-F
      if (c >= 8'h30 && c <= 8'h39) begin
         char_to_nib = {1'b0, c[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         char_to_nib = {1'b0, c[3:0] + 4'h9};
      end else begin
         char_to_nib = 5'h1_0;
      end
   endfunction

   // Format decode: data bits, parity, ASCII
   logic [3:0] fmt;
   logic seven;
   logic ascii;
   modbus_char_pkg::parity_e par;
   logic modbus;
   logic [15:0] bit_div;
   logic [3:0] nbits;
   logic [7:0] addr;
   always_comb begin
      fmt = q.ctrl[`CTRL_FMT_LSB +: 4];
      seven = (fmt <= 4'h2);
      modbus = q.ctrl[`CTRL_PROTO_BIT];
      ascii = modbus && (fmt <= 4'h5);
      unique case (fmt)
         4'h1, 4'h4, 4'h7: par = modbus_char_pkg::PAR_EVEN;
         4'h2, 4'h5, 4'h8: par = modbus_char_pkg::PAR_ODD;
         default: par = modbus_char_pkg::PAR_NONE;
      endcase
      unique case (q.ctrl[`CTRL_RATE_LSB +: 2])
         2'h0: bit_div = 16'(`DIV_4800);
         2'h1: bit_div = 16'(`DIV_9600);
         default: bit_div = 16'(`DIV_19200);
      endcase
      // Start + data + (parity,stop | stop,stop): 10 or 11 bits
      nbits = seven ? 4'd10 : 4'd11;
      addr = q.ctrl[`CTRL_ADDR_LSB +: 8];
   end

   logic wr_fire;
   logic rd_fire;
   logic [4:0] ev;
   logic [10:0] frame;
   logic [7:0] tx_char;
   logic pbit;
   logic [7:0] rx_char;
   logic rx_pbit;
   logic rx_stop;
   logic [4:0] dec;

   always_comb begin
      d = q;
      ev = 5'h0_0;
      s_axi_awready = !q.aw_got && !q.bvalid;
      s_axi_wready = !q.w_got && !q.bvalid;
      s_axi_arready = !q.rvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
      end
      wr_fire = q.aw_got && q.w_got;
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = 2'b00;
         unique case (q.awaddr)
            `REG_CTRL: begin
               d.ctrl = q.wdata;
               // Out-of-range address is refused and keeps its old value; the other fields are still written
               if (q.wdata[`CTRL_ADDR_LSB +: 8] < `ADDR_MIN ||
                   q.wdata[`CTRL_ADDR_LSB +: 8] > `ADDR_MAX) begin
                  d.ctrl[`CTRL_ADDR_LSB +: 8] = addr;
                  d.bresp = 2'b10;
               end
            end
            `REG_TXDATA: begin
               if (q.tx_busy) begin
                  d.bresp = 2'b10;
               end else begin
                  d.tx_busy = 1'b1;
                  d.tx_byte = q.wdata[7:0];
                  d.tx_second = 1'b0;
               end
            end
            `REG_IRQ_STAT: d.ist = q.ist & ~q.wdata[4:0];
            `REG_IRQ_MASK: d.imask = q.wdata[4:0];
            `REG_STATUS, `REG_RXDATA: ;
            default: d.bresp = 2'b10;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      rd_fire = s_axi_arvalid && s_axi_arready;
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rresp = 2'b00;
         unique case (s_axi_araddr)
            `REG_CTRL: d.rdata = q.ctrl;
            `REG_STATUS: d.rdata = {29'h0, q.rx_half, q.rx_full, q.tx_busy};
            `REG_RXDATA: begin
               d.rdata = {24'h0, q.rx_byte};
               d.rx_full = 1'b0;
            end
            `REG_IRQ_STAT: d.rdata = {27'h0, q.ist};
            `REG_IRQ_MASK: d.rdata = {27'h0, q.imask};
            `REG_TXDATA: d.rdata = 32'h0000_0000;
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = 2'b10;
            end
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end

      // Transmit: character to send this round
      if (ascii) begin
         tx_char = nib_to_char(q.tx_second ? q.tx_byte[3:0] :
                               q.tx_byte[7:4]);
      end else begin
         tx_char = q.tx_byte;
      end
      pbit = seven ? ^tx_char[6:0] : ^tx_char;
      if (par == modbus_char_pkg::PAR_ODD) begin
         pbit = !pbit;
      end
      if (seven) begin
         frame = {1'b1, 1'b1, (par == modbus_char_pkg::PAR_NONE) ? 1'b1 : pbit,
                  tx_char[6:0], 1'b0};
      end else begin
         frame = {1'b1, (par == modbus_char_pkg::PAR_NONE) ? 1'b1 : pbit,
                  tx_char, 1'b0};
      end
      unique case (q.tst)
         modbus_char_pkg::LN_IDLE: begin
            d.tx = 1'b1;
            if (q.tx_busy) begin
               d.tsh = frame;
               d.tbit = 4'h0;
               d.tcnt = 16'h0;
               d.txoe = 1'b1;
               d.tx = frame[0];
               d.tst = modbus_char_pkg::LN_BITS;
            end
         end
         modbus_char_pkg::LN_BITS: begin
            d.tcnt = q.tcnt + 16'h1;
            if (q.tcnt == bit_div - 16'h1) begin
               d.tcnt = 16'h0;
               d.tbit = q.tbit + 4'h1;
               d.tsh = {1'b1, q.tsh[10:1]};
               d.tx = q.tsh[1];
               if (q.tbit == nbits - 4'h1) begin
                  d.tx = 1'b1;
                  d.tst = modbus_char_pkg::LN_IDLE;
                  if (ascii && !q.tx_second) begin
                     d.tx_second = 1'b1;
                  end else begin
                     d.tx_busy = 1'b0;
                     d.txoe = 1'b0;
                     ev[`IRQ_TX_DONE] = 1'b1;
                  end
               end
            end
         end
         default: d.tst = modbus_char_pkg::LN_IDLE;
      endcase

      // Receive: sample mid-bit
      rx_char = seven ? {1'b0, q.rsh[7:1]} : q.rsh[8:1];
      rx_pbit = seven ? q.rsh[8] : q.rsh[9];
      rx_stop = q.rsh[nbits - 4'h1];
      dec = char_to_nib(rx_char);
      unique case (q.rst_)
         modbus_char_pkg::LN_IDLE: begin
            if (!line_rx && !q.txoe) begin
               d.rcnt = 16'h0;
               d.rbit = 4'h0;
               d.rst_ = modbus_char_pkg::LN_BITS;
            end
         end
         modbus_char_pkg::LN_BITS: begin
            d.rcnt = q.rcnt + 16'h1;
            if (q.rcnt == ((q.rbit == 4'h0) ? (bit_div >> 1) :
                           bit_div - 16'h1)) begin
               d.rcnt = 16'h0;
               d.rbit = q.rbit + 4'h1;
               d.rsh[q.rbit] = line_rx;
               if (q.rbit == 4'h0 && line_rx) begin
                  d.rst_ = modbus_char_pkg::LN_IDLE;
               end else if (q.rbit == nbits - 4'h1) begin
                  d.rst_ = modbus_char_pkg::LN_STOP;
               end
            end
         end
         modbus_char_pkg::LN_STOP: begin
            d.rst_ = modbus_char_pkg::LN_IDLE;
            if (!rx_stop || (par == modbus_char_pkg::PAR_NONE &&
                !q.rsh[nbits - 4'h2])) begin
               ev[`IRQ_FRAME_ERR] = 1'b1;
            end
            if (par != modbus_char_pkg::PAR_NONE &&
                ((seven ? ^rx_char[6:0] : ^rx_char) ^ rx_pbit ^
                 (par == modbus_char_pkg::PAR_ODD))) begin
               ev[`IRQ_PARITY_ERR] = 1'b1;
            end
            if (ascii) begin
               if (dec[4]) begin
                  ev[`IRQ_HEX_ERR] = 1'b1;
                  d.rx_half = 1'b0;
               end else if (!q.rx_half) begin
                  d.rx_hi = dec[3:0];
                  d.rx_half = 1'b1;
               end else begin
                  d.rx_byte = {q.rx_hi, dec[3:0]};
                  d.rx_half = 1'b0;
                  d.rx_full = 1'b1;
                  ev[`IRQ_RX_DONE] = 1'b1;
               end
            end else begin
               d.rx_byte = rx_char;
               d.rx_full = 1'b1;
               ev[`IRQ_RX_DONE] = 1'b1;
            end
         end
         default: d.rst_ = modbus_char_pkg::LN_IDLE;
      endcase
      d.ist = d.ist | ev;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.ctrl <= `CTRL_RESET;
         q.tst <= modbus_char_pkg::LN_IDLE;
         q.rst_ <= modbus_char_pkg::LN_IDLE;
         q.tx <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign line_tx = q.tx;
   assign line_tx_oe = q.txoe;
   assign irq = |(q.ist & q.imask);
endmodule // modbus_serial_char_codec

// ---- tb/codec_checker.sv ----
`timescale 1ns/1ps
module codec_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic line_tx,
   input wire logic line_tx_oe
);
   localparam int MIN_BIT = 25000000 / 19200;
   logic [15:0] low_q;
   logic [15:0] low_d;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Length of the current low stretch on the line
   always_comb low_d = line_tx ? 16'h0000 : low_q + 16'h0001;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) low_q <= 16'h0000;
      else low_q <= low_d;
   end
   a_b_follows: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while answer pending");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_wready)
      else $error("data taken while answer pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_idle_high: assert property (!line_tx_oe |-> line_tx)
      else $error("line low while released");
   a_stop_release: assert property ($fell(line_tx_oe) |->
      line_tx && $past(line_tx)) else $error("released without stop");
   a_min_bit: assert property ($rose(line_tx) && low_q != 16'h0000 |->
      low_q >= MIN_BIT) else $error("low bit shorter than a bit time");
   c_write: cover property (s_axi_bvalid);
   c_read: cover property (s_axi_rvalid);
   c_char: cover property ($fell(line_tx_oe));
endmodule // codec_checker
bind modbus_serial_char_codec codec_checker i_codec_checker (
   .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .line_tx(line_tx),
   .line_tx_oe(line_tx_oe)
);

// ---- tb/port_model.sv ----
`timescale 1ns/1ps
module port_model #(
   parameter int BIT_CYC = 1302
) (
   input wire logic sys_clk,
   input wire logic bus,
   input wire logic [3:0] nbits,
   output logic line_rx
);
   logic [10:0] got[$];
   int low_q = 0;
   int run = 0;
   initial line_rx = 1'b1;
   // Remembers the last low stretch seen on the bus
   always @(posedge sys_clk) begin
      if (!bus) run++;
      else begin
         if (run != 0) low_q = run;
         run = 0;
      end
   end
   // Samples each character mid-bit, start bit first
   always begin : capture
      logic [10:0] c;
      @(negedge bus);
      c = '1;
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int k = 0; k < nbits; k++) begin
         c[k] = bus;
         if (k < nbits - 1) repeat (BIT_CYC) @(posedge sys_clk);
      end
      got.push_back(c);
   end
   task automatic send_char(input logic [10:0] v);
      for (int k = 0; k < nbits; k++) begin
         line_rx <= v[k];
         repeat (BIT_CYC) @(posedge sys_clk);
      end
      line_rx <= 1'b1;
      @(posedge sys_clk);
   endtask
endmodule // port_model

// ---- tb/tb_modbus_serial_char_codec.sv ----
`timescale 1ns/1ps
module tb_modbus_serial_char_codec;
   localparam int BIT = 25000000 / 19200;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] nbits = 4'hB;
   logic awready, wready, bvalid, arready, rvalid, line_rx, line_tx;
   logic line_tx_oe, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   wire bus = line_tx_oe ? line_tx : 1'b1;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #20 sys_clk = ~sys_clk;
   modbus_serial_char_codec i_modbus_serial_char_codec (
      .sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .line_rx(line_rx), .line_tx(line_tx),
      .line_tx_oe(line_tx_oe), .irq(irq)
   );
   port_model #(.BIT_CYC(BIT)) i_port_model (
      .sys_clk(sys_clk), .bus(bus), .nbits(nbits), .line_rx(line_rx)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         fails++;
         test_done();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] er);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d & m, e);
   endtask
   task automatic poll(input int b, input logic v);
      logic [31:0] d;
      logic [1:0] r;
      do rd(12'h004, d, r); while (d[b] !== v);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rdc(12'h000, 32'hFFFF_FFFF, 32'h0001_0161);
      rd(12'h020, d, r);
      check(32'(r), 32'h0000_0002);
      for (int f = 0; f < 9; f++) begin
         wr(12'h000, {24'h00_FE01, 4'(f), 4'h2}, 2'h0);
         rdc(12'h000, 32'h00FF_01F3, {24'h00_FE01, 4'(f), 4'h2});
      end
      wr(12'h000, 32'h0000_0172, 2'h2);
      wr(12'h000, 32'h00FF_0172, 2'h2);
      rdc(12'h000, 32'h00FF_01F3, 32'h00FE_0172);
   endtask
   task automatic t_tx_rtu;
      wr(12'h014, 32'h0000_0001, 2'h0);
      wr(12'h008, 32'h0000_00A5, 2'h0);
      poll(0, 1'b0);
      check(32'(i_port_model.got.pop_front()),
         {21'h0, 1'b1, ^8'hA5, 8'hA5, 1'b0});
      check(32'(i_port_model.low_q), 32'(BIT));
      check(32'(irq), 32'h0000_0001);
      wr(12'h014, 32'h0000_0000, 2'h0);
      check(32'(irq), 32'h0000_0000);
      wr(12'h010, 32'h0000_0001, 2'h0);
      rdc(12'h010, 32'h0000_0001, 32'h0000_0000);
      wr(12'h014, 32'h0000_0002, 2'h0);
   endtask
   task automatic t_tx_ascii;
      wr(12'h000, 32'h00FE_0122, 2'h0);
      nbits <= 4'hA;
      wr(12'h008, 32'h0000_003C, 2'h0);
      poll(0, 1'b0);
      check(32'(i_port_model.got.pop_front()),
         {21'h0, 2'h3, ~^7'h33, 7'h33, 1'b0});
      check(32'(i_port_model.got.pop_front()),
         {21'h0, 2'h3, ~^7'h43, 7'h43, 1'b0});
   endtask
   task automatic t_rx_ascii;
      i_port_model.send_char({2'h3, ~^7'h46, 7'h46, 1'b0});
      i_port_model.send_char({2'h3, ~^7'h31, 7'h31, 1'b0});
      poll(1, 1'b1);
      check(32'(irq), 32'h0000_0001);
      rdc(12'h00C, 32'h0000_00FF, 32'h0000_00F1);
      wr(12'h010, 32'h0000_001F, 2'h0);
      check(32'(irq), 32'h0000_0000);
   endtask
   task automatic t_rx_err;
      // Bad odd parity on a non-hex character
      i_port_model.send_char({2'h3, ^7'h47, 7'h47, 1'b0});
      rdc(12'h010, 32'h0000_001C, 32'h0000_0018);
      wr(12'h010, 32'h0000_001F, 2'h0);
      // Raw serial: same character passes without hex decoding
      wr(12'h000, 32'h00FE_0022, 2'h0);
      i_port_model.send_char({2'h3, ~^7'h47, 7'h47, 1'b0});
      rdc(12'h00C, 32'h0000_00FF, 32'h0000_0047);
      rdc(12'h010, 32'h0000_001E, 32'h0000_0002);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs();
      t_tx_rtu();
      t_tx_ascii();
      t_rx_ascii();
      t_rx_err();
      test_done();
   end
endmodule // tb_modbus_serial_char_codec
